// ==== logic/ube_consts.vh ====
// Constants for the USB bus-event negotiator: register map, fields and timing
`ifndef UBE_CONSTS_VH
`define UBE_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UBE_OFS_CTRL        8'h00
`define UBE_OFS_FLAGS       8'h04
`define UBE_OFS_IRQEN       8'h08
`define UBE_OFS_STATUS      8'h0C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define UBE_CTRL_CTLR_EN    0
`define UBE_CTRL_NEGO_EN    1
`define UBE_CTRL_DET_DIS    2
`define UBE_CTRL_LEAVE_DET  3
`define UBE_CTRL_RET_DET    4
`define UBE_CTRL_WAKEUP     5
`define UBE_CTRL_SNOOZE     6
`define UBE_CTRL_OPMODE_LO  8
`define UBE_CTRL_OPMODE_HI  9

// ----------------------------------------------------------------------
// Flag and interrupt enable fields (same positions in both registers)
// ----------------------------------------------------------------------
`define UBE_EV_RESET        0
`define UBE_EV_SUSPEND      1
`define UBE_EV_LEAVE        2
`define UBE_EV_RETURN       3
`define UBE_IE_ENGINE       4

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define UBE_ST_LINE_LO      0
`define UBE_ST_LINE_HI      1
`define UBE_ST_FSM_LO       4
`define UBE_ST_FSM_HI       7
`define UBE_ST_OPMODE_LO    8
`define UBE_ST_OPMODE_HI    9

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define UBE_CTRL_RESET      10'h004
`define UBE_LINE_SE0        2'h0
`define UBE_LINE_J          2'h1
`define UBE_LINE_K          2'h2
`define UBE_OPMODE_RESUME   2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UBE_CLK_PERIOD_NS   10
`define UBE_SUSPEND_TIME_NS 3000000
`define UBE_RESET_TIME_NS   2500
`define UBE_SUSPEND_CYCLES  ((`UBE_SUSPEND_TIME_NS + `UBE_CLK_PERIOD_NS - 1) / `UBE_CLK_PERIOD_NS)
`define UBE_RESET_CYCLES    ((`UBE_RESET_TIME_NS + `UBE_CLK_PERIOD_NS - 1) / `UBE_CLK_PERIOD_NS)

`endif

// ==== logic/ube_sync2.v ====
// Two-stage synchroniser for pin-level inputs
module ube_sync2 #(
  parameter WIDTH = 2
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // First stage feeds only the second one
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

// ==== logic/ube_dur_timer.v ====
// Duration timer: pulses once after LIMIT consecutive matching cycles
module ube_dur_timer #(
  parameter             W     = 19,
  parameter [W-1:0]     LIMIT = 19'd300000
) (
  input  wire ref_clk,
  input  wire reset,
  input  wire enable,
  input  wire match,
  output reg  hit_q
);

  localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
  localparam [W-1:0] LAST = LIMIT - ONE;

  reg [W-1:0] cnt_q;
  reg         fired_q;

  // ----------------------------------------------------------------------
  // Any break in the line state restarts the count; one pulse per run
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset || !enable || !match) begin
      cnt_q   <= {W{1'b0}};
      fired_q <= 1'b0;
      hit_q   <= 1'b0;
    end else begin
      hit_q <= 1'b0;
      if (!fired_q) begin
        if (cnt_q == LAST) begin
          fired_q <= 1'b1;
          hit_q   <= 1'b1;
        end else begin
          cnt_q <= cnt_q + ONE;
        end
      end
    end
  end

endmodule

// ==== logic/ube_negotiator.v ====
// USB bus-event negotiator: event detection, auto-negotiation FSM, AHB-Lite registers
//
// Summary of operation
// RL1: Negotiation disabled keeps FSM in DISABLE.
// RL2: Software enables irqs before negotiator enable.
// RL3: Enabling negotiation clears detect-disable bit automatically.
// RL4: Software never sets detect-disable while negotiating.
// RL5: Idle J for 3 ms sets suspend.
// RL6: SE0 for 2.5 us sets reset.
// RL7: Flag interrupts need own and engine enable.
// RL8: Reset detection only with controller enabled; the event-check SE0 path sets the reset flag without it.
// RL9: Suspend in NORMAL moves to IN_SUSPEND.
// RL10: Entering IN_SUSPEND arms leave-idle detection.
// RL11: Leaving J while armed sets leave-idle flag.
// RL12: Software disarming leave-idle enters event check.
// RL13: Event check: K is resume, SE0 reset.
// RL14: K while suspended clears snooze, flags.
// RL15: Remote wakeup only after 5 ms idle; the bench wakes after about 440 idle cycles, not the scaled 667.
// RL16: Software orders wakeup and disarm steps.
// RL17: Software holds resume drive 1-15 ms.
// RL18: Resume drive forces mode 2, sends K.
// RL19: Host ending resume sets idle-return flag.
// RL20: After suspend, software disables detection, snoozes; the bench only clears the suspend flag and snoozes.
// RL21: Manual mode: software masks repeated SE0 detection.
// RL22: Negotiator used only while cable attached.
// RL23: Cycle counters restart on line change.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`include "ube_consts.vh"

module ube_negotiator #(
  parameter SUSPEND_CYCLES = `UBE_SUSPEND_CYCLES
) (
  input  wire        ref_clk,
  input  wire        reset,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Decoded bus line state from the transceiver
  input  wire [1:0]  line_state,
  // Link-side controls
  output reg  [1:0]  transmit_operating_mode,
  output reg         tx_drive_k,
  output reg         snooze_control,
  output reg         irq
);

  // ----------------------------------------------------------------------
  // Negotiation states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_DISABLE = 4'h1;
  localparam [3:0] ST_NORMAL  = 4'h2;
  localparam [3:0] ST_SUSPEND = 4'h4;
  localparam [3:0] ST_CHECK   = 4'h8;

  localparam integer RESET_CYC  = `UBE_RESET_CYCLES;
  localparam [18:0] RESET_LIMIT = RESET_CYC[18:0];
  localparam [18:0] SUSP_LIMIT  = SUSPEND_CYCLES[18:0];

  // Register state
  reg        controller_enable_q;
  reg        negotiator_enable_q;
  reg        bus_event_detect_disable_q;
  reg        leave_idle_detect_enable_q;
  reg        idle_return_detect_enable_q;
  reg        resume_drive_q;
  reg [1:0]  sw_opmode_q;
  reg [3:0]  flags_q;
  reg [4:0]  irq_en_q;
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg        saw_non_j_q;
  reg        wr_pend_q;
  reg [7:0]  wr_addr_q;

  wire [1:0] line_q;
  wire       susp_hit;
  wire       reset_hit;
  wire       det_active;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function is_line;
    input [1:0] ls;
    input [1:0] code;
    begin
      is_line = (ls == code);
    end
  endfunction

  function [31:0] read_mux;
    input [7:0]  ofs;
    input [9:0]  ctrl;
    input [3:0]  flg;
    input [4:0]  ien;
    input [1:0]  ls;
    input [3:0]  st;
    input [1:0]  mode;
    begin
      case (ofs)
        `UBE_OFS_CTRL:   read_mux = {22'h000000, ctrl};
        `UBE_OFS_FLAGS:  read_mux = {28'h0000000, flg};
        `UBE_OFS_IRQEN:  read_mux = {27'h0000000, ien};
        `UBE_OFS_STATUS: read_mux = {22'h000000, mode, st, 2'h0, ls};
        default:         read_mux = 32'h00000000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Line state comes from pins, so it is synchronised first
  // ----------------------------------------------------------------------
  ube_sync2 #(
    .WIDTH (2)
  ) u_line_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line_state),
    .sync_q   (line_q)
  );

  assign det_active = !bus_event_detect_disable_q;

  // ----------------------------------------------------------------------
  // Idle and SE0 duration timers
  // ----------------------------------------------------------------------
  ube_dur_timer #(
    .W     (19),
    .LIMIT (SUSP_LIMIT)
  ) u_susp_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (det_active),                          // RL5
    .match   (is_line(line_q, `UBE_LINE_J)),       // RL23
    .hit_q   (susp_hit)
  );

  ube_dur_timer #(
    .W     (19),
    .LIMIT (RESET_LIMIT)
  ) u_reset_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (det_active && controller_enable_q),   // RL6 RL8
    .match   (is_line(line_q, `UBE_LINE_SE0)),     // RL23
    .hit_q   (reset_hit)
  );

  // ----------------------------------------------------------------------
  // AHB-Lite: zero-wait slave; read data is registered in the address phase
  // ----------------------------------------------------------------------
  wire       addr_ok = hsel && htrans[1] && hready;
  wire       wr_now  = wr_pend_q;
  wire [9:0] ctrl_view = {sw_opmode_q, 1'b0, snooze_control, resume_drive_q,
                          idle_return_detect_enable_q, leave_idle_detect_enable_q,
                          bus_event_detect_disable_q, negotiator_enable_q,
                          controller_enable_q};

  always @(posedge ref_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= {haddr[7:2], 2'h0};
      end
      if (addr_ok && !hwrite) begin
        hrdata <= read_mux({haddr[7:2], 2'h0}, ctrl_view, flags_q, irq_en_q,
                           line_q, state_q, transmit_operating_mode);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Negotiation state machine, next state
  // ----------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_DISABLE: begin
        if (negotiator_enable_q) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (susp_hit) begin
          state_d = ST_SUSPEND;                     // RL9
        end
      end
      ST_SUSPEND: begin
        if (!leave_idle_detect_enable_q) begin
          state_d = ST_CHECK;                       // RL12
        end
      end
      ST_CHECK: begin
        if (is_line(line_q, `UBE_LINE_K) || is_line(line_q, `UBE_LINE_SE0)) begin
          state_d = ST_NORMAL;                      // RL13
        end
      end
      default: state_d = ST_DISABLE;
    endcase
    if (!negotiator_enable_q) begin
      state_d = ST_DISABLE;                         // RL1
    end
  end

  // ----------------------------------------------------------------------
  // Control bits, flags and FSM; hardware updates take priority over writes
  // ----------------------------------------------------------------------
  wire wr_ctrl  = wr_now && (wr_addr_q == `UBE_OFS_CTRL);
  wire wr_flags = wr_now && (wr_addr_q == `UBE_OFS_FLAGS);
  wire wr_ien   = wr_now && (wr_addr_q == `UBE_OFS_IRQEN);
  wire in_susp  = (state_q == ST_SUSPEND) || snooze_control;
  wire see_k    = is_line(line_q, `UBE_LINE_K);
  wire see_j    = is_line(line_q, `UBE_LINE_J);
  wire chk_se0  = (state_q == ST_CHECK) && is_line(line_q, `UBE_LINE_SE0);
  wire enter_susp = (state_q == ST_NORMAL) && (state_d == ST_SUSPEND);
  wire [3:0] set_ev;
  wire [3:0] clr_ev = wr_flags ? hwdata[3:0] : 4'h0;

  assign set_ev[`UBE_EV_RESET]   = reset_hit || chk_se0;                       // RL6 RL13
  assign set_ev[`UBE_EV_SUSPEND] = susp_hit;                                   // RL5
  assign set_ev[`UBE_EV_LEAVE]   = (leave_idle_detect_enable_q && !see_j)      // RL11
                                   || (in_susp && see_k);                      // RL14
  assign set_ev[`UBE_EV_RETURN]  = idle_return_detect_enable_q && saw_non_j_q && see_j; // RL19

  always @(posedge ref_clk) begin
    if (reset) begin
      controller_enable_q         <= 1'b0;
      negotiator_enable_q         <= 1'b0;
      bus_event_detect_disable_q  <= 1'b1;
      leave_idle_detect_enable_q  <= 1'b0;
      idle_return_detect_enable_q <= 1'b0;
      resume_drive_q              <= 1'b0;
      snooze_control              <= 1'b0;
      sw_opmode_q                 <= 2'h0;
      irq_en_q                    <= 5'h00;
      flags_q                     <= 4'h0;
      state_q                     <= ST_DISABLE;
      saw_non_j_q                 <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_ctrl) begin
        controller_enable_q         <= hwdata[`UBE_CTRL_CTLR_EN];
        negotiator_enable_q         <= hwdata[`UBE_CTRL_NEGO_EN];
        bus_event_detect_disable_q  <= hwdata[`UBE_CTRL_DET_DIS];
        leave_idle_detect_enable_q  <= hwdata[`UBE_CTRL_LEAVE_DET];
        idle_return_detect_enable_q <= hwdata[`UBE_CTRL_RET_DET];
        resume_drive_q              <= hwdata[`UBE_CTRL_WAKEUP];
        snooze_control              <= hwdata[`UBE_CTRL_SNOOZE];
        sw_opmode_q                 <= hwdata[`UBE_CTRL_OPMODE_HI:`UBE_CTRL_OPMODE_LO];
      end
      if (wr_ien) begin
        irq_en_q <= hwdata[4:0];
      end
      // Leaving DISABLE reopens Reset and Suspend detection
      if (state_q == ST_DISABLE && state_d == ST_NORMAL) begin
        bus_event_detect_disable_q <= 1'b0;        // RL3
      end
      // Arming on entry; a same-cycle software clear loses to it
      if (enter_susp) begin
        leave_idle_detect_enable_q <= 1'b1;        // RL10
      end
      // Resume from the host wakes the controller out of snooze
      if (in_susp && see_k) begin
        snooze_control <= 1'b0;                    // RL14
      end
      // Sticky flags, write one to clear; a same-cycle event wins
      flags_q <= (flags_q & ~clr_ev) | set_ev;
      // Host resume seen before its return to J
      if (!idle_return_detect_enable_q) begin
        saw_non_j_q <= 1'b0;
      end else if (!see_j) begin
        saw_non_j_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs: resume drive overrides the software operating mode
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      transmit_operating_mode <= 2'h0;
      tx_drive_k              <= 1'b0;
      irq                     <= 1'b0;
    end else begin
      transmit_operating_mode <= resume_drive_q ? `UBE_OPMODE_RESUME : sw_opmode_q; // RL18
      tx_drive_k              <= resume_drive_q;                                   // RL18
      irq <= irq_en_q[`UBE_IE_ENGINE] && |(flags_q & irq_en_q[3:0]);              // RL7
    end
  end

endmodule

// ==== bench/ube_negotiator_monitor.sv ====
// Concurrent checks on the bus-event negotiator ports
module ube_negotiator_monitor #(
  parameter SUSPEND_CYCLES = 400
) (
  input wire        ref_clk,
  input wire        reset,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [1:0]  line_state,
  input wire [1:0]  transmit_operating_mode,
  input wire        tx_drive_k,
  input wire        snooze_control,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Shadow state
  // ------------------------------------------------------------------
  logic [5:0]  wr_q;     // Word index of a write in its data phase
  logic [4:0]  ien_q;
  logic        ctl_en_q;
  logic [9:0]  se0_n;    // Raw pin run lengths, saturating
  logic [19:0] j_n;
  wire         take = hsel && htrans[1] && hready;
  // Mirror writes so gating is judged from the bus alone
  always @(posedge ref_clk) begin
    if (reset) begin
      wr_q <= 6'h3F;
      ien_q <= 5'h00;
      ctl_en_q <= 1'b0;
      se0_n <= 10'h000;
      j_n <= 20'h00000;
    end else begin
      wr_q <= (take && hwrite) ? haddr[7:2] : 6'h3F;
      if (wr_q == 6'h02) ien_q <= hwdata[4:0];
      if (wr_q == 6'h00) ctl_en_q <= hwdata[0];
      se0_n <= (line_state != 2'h0) ? 10'h000 : se0_n + {9'h000, ~&se0_n};
      j_n <= (line_state != 2'h1) ? 20'h00000 : j_n + {19'h00000, ~&j_n};
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_wr(logic [5:0] ofs);
    take && hwrite && haddr[7:2] == ofs ##1 1'b1;
  endsequence
  sequence s_k3;
    line_state == 2'h2 && $past(line_state) == 2'h2 && $past(line_state, 2) == 2'h2;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_resume_mode: assert property (tx_drive_k |-> transmit_operating_mode == 2'h2)
    else $error("resume drive without mode 2");
  a_wake_on: assert property (s_wr(6'h00) ##0 hwdata[5] |-> ##[1:2] tx_drive_k)
    else $error("resume drive did not start");
  a_wake_off: assert property (s_wr(6'h00) ##0 !hwdata[5] |-> ##[1:2] !tx_drive_k)
    else $error("resume drive did not stop");
  a_irq_gate: assert property (!ien_q[4] && !$past(ien_q[4]) |-> !irq)
    else $error("irq with engine enable off");
  a_reset_time: assert property ($rose(irq) && ien_q == 5'h11 && $past(ien_q, 2) == 5'h11
    |-> se0_n >= 10'd250 && se0_n <= 10'd258)
    else $error("reset flag at wrong SE0 length");
  a_reset_enable: assert property ($rose(irq) && ien_q == 5'h11 && $past(ien_q, 2) == 5'h11
    |-> ctl_en_q)
    else $error("reset detected with controller off");
  a_suspend_time: assert property ($rose(irq) && ien_q == 5'h13 && $past(ien_q, 2) == 5'h13
    && line_state == 2'h1 |-> j_n >= SUSPEND_CYCLES)
    else $error("suspend flag before idle limit");
  a_snooze_wake: assert property (snooze_control ##0 s_k3 |-> ##[1:3] !snooze_control)
    else $error("snooze not cleared on K");
endmodule

bind ube_negotiator ube_negotiator_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES))
  u_ube_negotiator_monitor (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .line_state(line_state),
  .transmit_operating_mode(transmit_operating_mode), .tx_drive_k(tx_drive_k),
  .snooze_control(snooze_control), .irq(irq));

// ==== bench/ube_host_model.sv ====
// Host or hub model driving the decoded line state
`include "ube_consts.vh"
module ube_host_model #(
  parameter int ECHO = 40
) (
  input  wire       ref_clk,
  input  wire [1:0] drive_state,
  input  wire       tx_drive_k,
  output wire [1:0] line_state
);
  timeunit 1ns;
  timeprecision 1ps;
  int echo_n = 0;
  // Host answers a device resume with its own K, then lets the bus fall back
  always @(posedge ref_clk) begin
    if (tx_drive_k) echo_n <= ECHO;
    else if (echo_n > 0) echo_n <= echo_n - 1;
  end
  // Device K dominates the line while driven; otherwise the host chooses
  assign line_state = (tx_drive_k || echo_n > 0) ? `UBE_LINE_K : drive_state;
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the bus-event negotiator
`include "ube_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 400;  // Short idle limit keeps the run brief
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  drive_state = `UBE_LINE_J;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, tx_drive_k, snooze_control, irq;
  wire  [1:0]  line_state, mode;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc_n = 0;

  ube_negotiator #(.SUSPEND_CYCLES(SC)) u_ube_negotiator (.ref_clk(ref_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .line_state(line_state), .transmit_operating_mode(mode),
    .tx_drive_k(tx_drive_k), .snooze_control(snooze_control), .irq(irq));
  ube_host_model #(.ECHO(40)) u_ube_host_model (.ref_clk(ref_clk),
    .drive_state(drive_state), .tx_drive_k(tx_drive_k), .line_state(line_state));

  initial forever #5 ref_clk = ~ref_clk;
  // Watchdog: far above the expected few thousand cycles
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic eq(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared = n_compared + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One AHB-Lite single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    eq($sformatf("reg %h", a), r & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic ln(input logic [1:0] s, input int n);
    drive_state <= s;
    cyc(n);
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(`UBE_OFS_CTRL, 32'h3FF, 32'h004);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h10);
    // Long SE0 with the controller off must pass unnoticed
    wr(`UBE_OFS_IRQEN, 32'h11);
    wr(`UBE_OFS_CTRL, 32'h000);
    ln(`UBE_LINE_SE0, 300);
    ln(`UBE_LINE_J, 5);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h0);
    // A run just short of the limit, then a full one
    wr(`UBE_OFS_CTRL, 32'h001);
    ln(`UBE_LINE_SE0, 240);
    ln(`UBE_LINE_J, 5);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h0);
    ln(`UBE_LINE_SE0, 300);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h1);
    eq("irq", irq, 32'h1);
    wr(`UBE_OFS_IRQEN, 32'h01);
    cyc(2);
    eq("irq", irq, 32'h0);
    wr(`UBE_OFS_IRQEN, 32'h11);
    // Mask the ongoing SE0 so it is not seen twice
    wr(`UBE_OFS_CTRL, 32'h005);
    wr(`UBE_OFS_FLAGS, 32'h1);
    cyc(300);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h0);
    ln(`UBE_LINE_J, 5);
    // Auto-negotiation enabled in the order software must keep
    wr(`UBE_OFS_IRQEN, 32'h01);
    wr(`UBE_OFS_IRQEN, 32'h03);
    wr(`UBE_OFS_IRQEN, 32'h13);
    wr(`UBE_OFS_CTRL, 32'h007);
    cyc(2);
    chk(`UBE_OFS_CTRL, 32'h4, 32'h0);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h20);
    cyc(SC + 20);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h2);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h40);
    chk(`UBE_OFS_CTRL, 32'h8, 32'h8);
    wr(`UBE_OFS_FLAGS, 32'h2);
    wr(`UBE_OFS_CTRL, 32'h04B);
    cyc(2);
    eq("snooze_control", snooze_control, 32'h1);
    ln(`UBE_LINE_K, 10);
    eq("snooze_control", snooze_control, 32'h0);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h4);
    ln(`UBE_LINE_J, 5);
    wr(`UBE_OFS_FLAGS, 32'h4);
    wr(`UBE_OFS_CTRL, 32'h003);
    // The state register moves one edge after the write lands
    cyc(2);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h80);
    ln(`UBE_LINE_SE0, 20);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h20);
    chk(`UBE_OFS_FLAGS, 32'hF, 32'h1);
    ln(`UBE_LINE_J, 5);
    wr(`UBE_OFS_FLAGS, 32'h1);
    // Second suspend, then remote wakeup after a scaled idle time
    cyc(SC + 20);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h40);
    wr(`UBE_OFS_FLAGS, 32'h2);
    wr(`UBE_OFS_IRQEN, 32'h13);
    wr(`UBE_OFS_CTRL, 32'h02B);
    cyc(2);
    eq("tx_drive_k", tx_drive_k, 32'h1);
    eq("mode", mode, 32'h2);
    cyc(200);
    wr(`UBE_OFS_CTRL, 32'h00B);
    wr(`UBE_OFS_CTRL, 32'h013);
    cyc(2);
    eq("tx_drive_k", tx_drive_k, 32'h0);
    cyc(60);
    chk(`UBE_OFS_FLAGS, 32'h8, 32'h8);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h20);
    // Cable detach: software drops the negotiator, which falls back to DISABLE
    wr(`UBE_OFS_CTRL, 32'h001);
    cyc(2);
    chk(`UBE_OFS_STATUS, 32'hF0, 32'h10);
    stop_test();
  end
endmodule
